// ---- core/vsm_cfg.svh ----
/*
  Constants for the short I/O mailbox slave: modifier codes, size codes,
  field positions and timing counts.
  Assumes a 100 MHz core clock and host pins already synchronous to it.
*/
// Summary of operation
// - two independent slave windows, each separately configured
// - window length 256, 512, 1K or 2K bytes
// - match A15-A08 against window config, modifier against fixed codes
// - only modifier codes 2D or 29 accepted
// - slave only, never requests bus mastership
// - byte, word and longword transfers supported
// - accesses land in shared local processor SRAM
// - reset and mailbox hits reported to processor
// - host writes commands, processor writes status back
`ifndef VSM_CFG_SVH
`define VSM_CFG_SVH

`define VSM_AM_SUP      6'h2d
`define VSM_AM_USR      6'h29
`define VSM_SIZE_256    2'h0
`define VSM_SIZE_512    2'h1
`define VSM_SIZE_1K     2'h2
`define VSM_SIZE_2K     2'h3
`define VSM_ADDR_W      11
`define VSM_RST_OFS     11'h000
`define VSM_MBX_OFS     11'h004
`define VSM_WIN_SEL_BIT 11
`define VSM_DTACK_NS    30
`define VSM_CLK_NS      10
`define VSM_DTACK_CYC   ((`VSM_DTACK_NS + `VSM_CLK_NS - 1) / `VSM_CLK_NS)

`endif

// ---- core/vsm_pkg.sv ----
/*
  Types shared by the short I/O mailbox slave.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package vsm_pkg;
  typedef enum logic [1:0] {
    VSM_ST_IDLE,
    VSM_ST_MEM,
    VSM_ST_ACK,
    VSM_ST_DONE
  } vsm_state_t;

  typedef logic [1:0] vsm_size_t;
endpackage
`default_nettype wire

// ---- core/vsm_win_match.sv ----
/*
  One short I/O window comparator.
  Assumes address and modifier are stable while the strobe is active.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vsm_cfg.svh"
module vsm_win_match
  import vsm_pkg::*;
(
  input  wire logic [15:8]     i_addr,     // host address a15..a08
  input  wire logic [5:0]      i_am,       // address modifier
  input  wire logic [15:8]     i_base,     // window base a15..a08
  input  wire vsm_pkg::vsm_size_t i_size,  // window length code
  input  wire logic            i_enable,   // window enabled
  output logic                 o_hit       // address falls in window
);
  import vsm_pkg::*;

  logic [7:0] mask;
  logic       am_ok;

  // low bits of the compare are dropped as the window grows
  always_comb begin
    case (i_size)
      `VSM_SIZE_256: mask = 8'hff;
      `VSM_SIZE_512: mask = 8'hfe;
      `VSM_SIZE_1K:  mask = 8'hfc;
      default:       mask = 8'hf8;
    endcase
    am_ok = (i_am == `VSM_AM_SUP) || (i_am == `VSM_AM_USR);
    o_hit = i_enable && am_ok &&
            (((i_addr ^ i_base) & mask) == 8'h00);
  end
endmodule
`default_nettype wire

// ---- core/vsm_mailbox_slave.sv ----
/*
  Short I/O mailbox slave: decodes two host windows, moves byte, word or
  longword data to and from the processor SRAM port, acknowledges the
  host and flags reset and mailbox hits to the local processor.
  Assumes host signals are synchronous to i_core_clk, the SRAM port
  answers its request after any number of wait cycles, and the processor shares
  that SRAM through its own arbitration.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vsm_cfg.svh"
module vsm_mailbox_slave
  import vsm_pkg::*;
(
  input  wire logic        i_core_clk,   // core clock, 100 MHz
  input  wire logic        i_rst_b,      // async reset, active low
  // host side
  input  wire logic        i_as_b,       // address strobe, low active
  input  wire logic [1:0]  i_ds_b,       // data strobes, low active
  input  wire logic        i_write_b,    // low for write
  input  wire logic        i_lword_b,    // low for 32-bit transfer
  input  wire logic [15:1] i_addr,       // host address
  input  wire logic [5:0]  i_am,         // address modifier
  input  wire logic [31:0] i_data,       // host write data
  output logic [31:0]      o_data,       // host read data
  output logic             o_data_oe_b,  // read data drive, low active
  output logic             o_dtack_b,    // acknowledge, low active
  // window configuration straps
  input  wire logic [15:8] i_win0_base,  // window 0 base
  input  wire vsm_pkg::vsm_size_t i_win0_size, // window 0 length
  input  wire logic        i_win0_en,    // window 0 enable
  input  wire logic [15:8] i_win1_base,  // window 1 base
  input  wire vsm_pkg::vsm_size_t i_win1_size, // window 1 length
  input  wire logic        i_win1_en,    // window 1 enable
  // processor sram port
  output logic             o_mem_req,    // sram access request
  output logic             o_mem_we,     // sram write
  output logic [11:0]      o_mem_addr,   // window select + byte offset
  output logic [3:0]       o_mem_be,     // byte enables
  output logic [31:0]      o_mem_wdata,  // sram write data
  input  wire logic [31:0] i_mem_rdata,  // sram read data
  input  wire logic        i_mem_ack,    // sram access done
  // processor notification
  output logic             o_reset_hit,  // host touched reset location
  output logic             o_mbox_hit,   // host touched mailbox
  input  wire logic        i_hit_clr     // processor clears both flags
);
  import vsm_pkg::*;

  // ----------------------------------------------------------------
  // window decode
  // ----------------------------------------------------------------
  logic hit0;
  logic hit1;

  vsm_win_match u_win0 (
    .i_addr   (i_addr[15:8]),
    .i_am     (i_am),
    .i_base   (i_win0_base),
    .i_size   (i_win0_size),
    .i_enable (i_win0_en),
    .o_hit    (hit0)
  );
  vsm_win_match u_win1 (
    .i_addr   (i_addr[15:8]),
    .i_am     (i_am),
    .i_base   (i_win1_base),
    .i_size   (i_win1_size),
    .i_enable (i_win1_en),
    .o_hit    (hit1)
  );

  // ----------------------------------------------------------------
  // offset and byte lanes
  // ----------------------------------------------------------------
  logic [10:0] ofs;
  logic [3:0]  be;
  logic        cycle;

  always_comb begin
    ofs   = {i_addr[10:1], 1'b0} & {2'b11, 9'h1fe};
    cycle = !i_as_b && (i_ds_b != 2'b11);
    // lanes: ds1 is the even byte, lword widens to all four
    if (!i_lword_b) begin
      be = 4'hf;
    end else if (i_addr[1]) begin
      be = {2'b00, !i_ds_b[1], !i_ds_b[0]};
    end else begin
      be = {!i_ds_b[1], !i_ds_b[0], 2'b00};
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  vsm_state_t  state;
  vsm_state_t  next_state;
  logic [1:0]  cnt;
  logic [1:0]  next_cnt;
  logic        req;
  logic        next_req;
  logic        we;
  logic        next_we;
  logic [11:0] maddr;
  logic [11:0] next_maddr;
  logic [3:0]  mbe;
  logic [3:0]  next_mbe;
  logic [31:0] wdata;
  logic [31:0] next_wdata;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        oe_b;
  logic        next_oe_b;
  logic        dtack_b;
  logic        next_dtack_b;
  logic        rst_hit;
  logic        next_rst_hit;
  logic        mbx_hit;
  logic        next_mbx_hit;

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_req     = 1'b0;
    next_we      = we;
    next_maddr   = maddr;
    next_mbe     = mbe;
    next_wdata   = wdata;
    next_rdata   = rdata;
    next_oe_b    = oe_b;
    next_dtack_b = dtack_b;
    next_rst_hit = rst_hit;
    next_mbx_hit = mbx_hit;
    // processor clear loses to a simultaneous new hit
    if (i_hit_clr) begin
      next_rst_hit = 1'b0;
      next_mbx_hit = 1'b0;
    end
    case (state)
      VSM_ST_IDLE: begin
        // a miss is simply ignored: no ack, no store, no flag
        if (cycle && (hit0 || hit1)) begin
          next_state = VSM_ST_MEM;
          next_req   = 1'b1;
          next_we    = !i_write_b;
          next_maddr = {hit1 && !hit0, ofs};
          next_mbe   = be;
          next_wdata = i_data;
          if ({ofs[10:2], 2'b00} == `VSM_RST_OFS) begin
            next_rst_hit = 1'b1;
          end else if ({ofs[10:2], 2'b00} >= `VSM_MBX_OFS) begin
            next_mbx_hit = 1'b1;
          end
        end
      end
      VSM_ST_MEM: begin
        if (i_mem_ack) begin
          next_rdata = i_mem_rdata;
          next_oe_b  = we;
          next_cnt   = 2'(`VSM_DTACK_CYC);
          next_state = VSM_ST_ACK;
        end else begin
          next_req = 1'b1;
        end
      end
      VSM_ST_ACK: begin
        // hold data a few cycles before acknowledging for setup
        if (cnt == 2'h0) begin
          next_dtack_b = 1'b0;
          next_state   = VSM_ST_DONE;
        end else begin
          next_cnt = cnt - 2'h1;
        end
      end
      default: begin
        // release once the master drops its strobes
        if (i_as_b || (i_ds_b == 2'b11)) begin
          next_dtack_b = 1'b1;
          next_oe_b    = 1'b1;
          next_state   = VSM_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state   <= VSM_ST_IDLE;
      cnt     <= 2'h0;
      req     <= 1'b0;
      we      <= 1'b0;
      maddr   <= 12'h000;
      mbe     <= 4'h0;
      wdata   <= 32'h0000_0000;
      rdata   <= 32'h0000_0000;
      oe_b    <= 1'b1;
      dtack_b <= 1'b1;
      rst_hit <= 1'b0;
      mbx_hit <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      req     <= next_req;
      we      <= next_we;
      maddr   <= next_maddr;
      mbe     <= next_mbe;
      wdata   <= next_wdata;
      rdata   <= next_rdata;
      oe_b    <= next_oe_b;
      dtack_b <= next_dtack_b;
      rst_hit <= next_rst_hit;
      mbx_hit <= next_mbx_hit;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // no bus request output exists: this block only answers cycles
  assign o_data      = rdata;
  assign o_data_oe_b = oe_b;
  assign o_dtack_b   = dtack_b;
  assign o_mem_req   = req;
  assign o_mem_we    = we;
  assign o_mem_addr  = maddr;
  assign o_mem_be    = mbe;
  assign o_mem_wdata = wdata;
  assign o_reset_hit = rst_hit;
  assign o_mbox_hit  = mbx_hit;
endmodule
`default_nettype wire

// ---- bench/vsm_mailbox_slave_checker.sv ----
/*
  Assertions on the host and sram ports of the mailbox slave.
  Assumes a bind onto every vsm_mailbox_slave instance.
*/
`timescale 1ns/1ps
`default_nettype none
module vsm_mailbox_slave_checker (
  input wire logic        i_core_clk,  // clock
  input wire logic        i_rst_b,     // reset
  input wire logic        i_as_b,      // strobe
  input wire logic [1:0]  i_ds_b,      // lanes
  input wire logic        i_write_b,   // write
  input wire logic        i_lword_b,   // 32 bit
  input wire logic [15:1] i_addr,      // address
  input wire logic [5:0]  i_am,        // modifier
  input wire logic        o_data_oe_b, // read drive
  input wire logic        o_dtack_b,   // ack
  input wire logic        o_mem_req,   // sram req
  input wire logic        o_mem_we,    // sram write
  input wire logic [11:0] o_mem_addr,  // sram addr
  input wire logic [3:0]  o_mem_be,    // lanes
  input wire logic        i_mem_ack    // sram done
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  am_filter_a: assert property (
    $rose(o_mem_req) |-> $past(i_am) == 6'h2d || $past(i_am) == 6'h29)
    else $error("request on bad modifier");
  lword_lanes_a: assert property (
    $rose(o_mem_req) && !$past(i_lword_b) |-> o_mem_be == 4'hf)
    else $error("longword lanes wrong");
  offset_map_a: assert property (
    $rose(o_mem_req) |-> o_mem_addr[7:1] == $past(i_addr[7:1])
    && o_mem_we == !$past(i_write_b)) else $error("sram offset wrong");
  req_hold_a: assert property (
    o_mem_req && !i_mem_ack |=> o_mem_req) else $error("request dropped");
  req_drop_a: assert property (
    o_mem_req && i_mem_ack |=> !o_mem_req) else $error("request stuck");
  ack_delay_a: assert property (
    $fell(o_dtack_b) |-> $past(i_mem_ack, 5)) else $error("ack delay");
  ack_release_a: assert property (
    !o_dtack_b && (i_as_b || i_ds_b == 2'h3) |=> o_dtack_b)
    else $error("ack held after release");
  read_drive_a: assert property (
    $fell(o_dtack_b) |-> o_data_oe_b == !i_write_b)
    else $error("read drive wrong");
endmodule
bind vsm_mailbox_slave vsm_mailbox_slave_checker i_chk (.i_core_clk,
  .i_rst_b, .i_as_b, .i_ds_b, .i_write_b, .i_lword_b, .i_addr, .i_am,
  .o_data_oe_b, .o_dtack_b, .o_mem_req, .o_mem_we, .o_mem_addr,
  .o_mem_be, .i_mem_ack);
`default_nettype wire

// ---- bench/vsm_sram_model.sv ----
/*
  Behavioural shared sram behind the slave's memory port.
  Assumes one request at a time; bench may preload mem directly.
*/
`timescale 1ns/1ps
`default_nettype none
module vsm_sram_model (
  input  wire logic        i_clk,   // clock
  input  wire logic        i_rst_b, // reset
  input  wire logic        i_slow,  // three wait cycles
  input  wire logic        i_req,   // request
  input  wire logic        i_we,    // write
  input  wire logic [11:0] i_addr,  // byte address
  input  wire logic [3:0]  i_be,    // lanes
  input  wire logic [31:0] i_wdata, // write data
  output logic [31:0]      o_rdata, // read data
  output logic             o_ack    // done pulse
);
  logic [7:0] mem [0:4095];
  logic [1:0] wait_cnt;
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ack <= 1'b0;
      wait_cnt <= 2'h0;
      o_rdata <= 32'h0;
    end else begin
      o_ack <= 1'b0;
      wait_cnt <= 2'h0;
      // outside the ack, read data toggles to its inverse every cycle
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack && wait_cnt != (i_slow ? 2'h3 : 2'h0)) begin
        wait_cnt <= wait_cnt + 2'h1;
      end else if (i_req && !o_ack) begin
        o_ack <= 1'b1;
        for (int k = 0; k < 4; k++) begin
          o_rdata[31-8*k -: 8] <= mem[{i_addr[11:2], 2'(k)}];
          if (i_we && i_be[3-k]) begin
            mem[{i_addr[11:2], 2'(k)}] <= i_wdata[31-8*k -: 8];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/vsm_mailbox_slave_bench.sv ----
/*
  Bench for the mailbox slave acting as host, sram model behind it.
  Assumes the checker bind and vsm_sram_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module vsm_mailbox_slave_bench;
  logic        clk = 0, rst_b = 0, as_b = 1, wr_b = 1, lw_b = 1;
  logic        slow = 0, clr = 0, w1en = 1, ack, oe_b, dt_b, req, we;
  logic        rhit, mhit, ok;
  logic [1:0]  ds_b = 2'h3, w0sz = 2'h0;
  logic [15:1] addr = '0;
  logic [5:0]  am = 6'h2d;
  logic [31:0] wd = '0, rd, q, mrd, mwd;
  logic [11:0] ma;
  logic [3:0]  be;
  int          n_fail = 0, tests_run = 0;
  always #5 clk = ~clk;
  vsm_mailbox_slave i_vsm_mailbox_slave (.i_core_clk(clk),
    .i_rst_b(rst_b), .i_as_b(as_b), .i_ds_b(ds_b), .i_write_b(wr_b),
    .i_lword_b(lw_b), .i_addr(addr), .i_am(am), .i_data(wd),
    .o_data(rd), .o_data_oe_b(oe_b), .o_dtack_b(dt_b),
    .i_win0_base(8'h10), .i_win0_size(w0sz), .i_win0_en(1'b1),
    .i_win1_base(8'h20), .i_win1_size(2'h3), .i_win1_en(w1en),
    .o_mem_req(req), .o_mem_we(we), .o_mem_addr(ma), .o_mem_be(be),
    .o_mem_wdata(mwd), .i_mem_rdata(mrd), .i_mem_ack(ack),
    .o_reset_hit(rhit), .o_mbox_hit(mhit), .i_hit_clr(clr));
  vsm_sram_model i_vsm_sram_model (.i_clk(clk), .i_rst_b(rst_b),
    .i_slow(slow), .i_req(req), .i_we(we), .i_addr(ma), .i_be(be),
    .i_wdata(mwd), .o_rdata(mrd), .o_ack(ack));
  task automatic check(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // one host cycle, held until ack or timeout
  // ----------------------------------------
  task automatic host(input logic w, l, input logic [1:0] d,
                      input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    #1;
    as_b = 0;
    ds_b = d;
    wr_b = !w;
    lw_b = !l;
    addr = a[15:1];
    wd = v;
    ok = 0;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clk);
      ok = (dt_b === 1'b0);
      q = rd;
    end
    #1;
    as_b = 1;
    ds_b = 2'h3;
    // released lines show the inverse, not a stale value
    wd = ~v;
    @(posedge clk);
    #1;
  endtask
  task automatic t_lanes;
    host(1, 1, 2'h0, 16'h1008, 32'h1234_5678);
    host(1, 0, 2'h1, 16'h100a, 32'h0000_5a00);
    host(1, 0, 2'h0, 16'h1008, 32'hbeef_0000);
    // odd lane only on the upper word: bits 23:16
    host(1, 0, 2'h2, 16'h1008, 32'h00ad_0000);
    am = 6'h29;
    host(0, 1, 2'h0, 16'h1008, 32'h0);
    check("lanes", 32'hbead_5a78, q);
    am = 6'h2d;
  endtask
  task automatic t_windows;
    host(1, 1, 2'h0, 16'h27fc, 32'hcafe_f00d);
    check("win1 sel", 32'hca, 32'(i_vsm_sram_model.mem[12'hffc]));
    host(1, 1, 2'h0, 16'h1108, 32'h1);
    check("miss 256", 32'h0, 32'(ok));
    w0sz = 2'h1;
    host(1, 1, 2'h0, 16'h1108, 32'h1);
    check("hit 512", 32'h1, 32'(ok));
    host(1, 1, 2'h0, 16'h1308, 32'h0);
    check("miss 512", 32'h0, 32'(ok));
    w0sz = 2'h2;
    host(1, 1, 2'h0, 16'h1308, 32'h0);
    check("hit 1k", 32'h1, 32'(ok));
    w0sz = 2'h1;
    w1en = 0;
    host(0, 1, 2'h0, 16'h27fc, 32'h0);
    check("win1 off", 32'h0, 32'(ok));
    w1en = 1;
    am = 6'h39;
    host(1, 1, 2'h0, 16'h1008, 32'h0);
    check("bad am", 32'h0, 32'(ok));
    am = 6'h2d;
    host(0, 1, 2'h0, 16'h1008, 32'h0);
    check("kept", 32'hbead_5a78, q);
  endtask
  task automatic t_flags;
    @(posedge clk);
    #1;
    clr = 1;
    @(posedge clk);
    #1;
    clr = 0;
    am = 6'h39;
    host(1, 1, 2'h0, 16'h1000, 32'h0);
    check("no flag", 32'h0, {30'h0, rhit, mhit});
    am = 6'h2d;
    host(1, 1, 2'h0, 16'h1000, 32'h0);
    check("reset hit", 32'h2, {30'h0, rhit, mhit});
    host(1, 1, 2'h0, 16'h1004, 32'h0);
    check("mbox hit", 32'h3, {30'h0, rhit, mhit});
    // clear pulse lands on the take edge of a reset hit
    fork
      host(1, 1, 2'h0, 16'h1000, 32'h0);
      begin
        @(posedge clk);
        #1;
        clr = 1;
        @(posedge clk);
        #1;
        clr = 0;
      end
    join
    check("set wins", 32'h2, {30'h0, rhit, mhit});
  endtask
  task automatic t_status;
    // status placed by the processor side, read slowly by host
    for (int k = 0; k < 4; k++) begin
      i_vsm_sram_model.mem[12'h010 + k] = 8'(k + 1);
    end
    slow = 1;
    host(0, 1, 2'h0, 16'h1010, 32'h0);
    check("status", 32'h0102_0304, q);
    slow = 0;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1;
    t_lanes();
    t_windows();
    t_flags();
    t_status();
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule
`default_nettype wire
